// File: verilog/mtc_params.svh
// Register offsets, codes, multicast prefixes and key width of the station table engine.
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH
// ****************************************
// Register offsets
// ****************************************
`define MTC_OFF_LDATA  8'h00
`define MTC_OFF_HDATA  8'h04
`define MTC_OFF_INDEX  8'h08
`define MTC_OFF_ACCESS 8'h0C
`define MTC_OFF_FILTER 8'h10
`define MTC_OFF_PORTS  8'h14
`define MTC_OFF_DMACL  8'h18
`define MTC_OFF_DMACH  8'h1C
// ****************************************
// Command codes
// ****************************************
`define MTC_CMD_IDLE   3'h0
`define MTC_CMD_LEARN  3'h1
`define MTC_CMD_UNLRN  3'h2
`define MTC_CMD_AGE    3'h3
`define MTC_CMD_READ   3'h4
`define MTC_CMD_WRITE  3'h5
`define MTC_CMD_INIT   3'h6
`define MTC_CMD_GNEXT  3'h7
// ****************************************
// Entry type codes and multicast prefixes
// ****************************************
`define MTC_TYPE_AGING 2'h0
`define MTC_TYPE_LOCK  2'h1
`define MTC_TYPE_IPV4  2'h2
`define MTC_TYPE_IPV6  2'h3
`define MTC_V4_PREFIX  24'h01_005E
`define MTC_V6_PREFIX  16'h3333
`define MTC_KEY_W      60
`endif

// File: verilog/mtc_pkg.sv
// Types shared by the station table engine.
package mtc_pkg;
  // One stored station entry; the valid bit is kept apart.
  typedef struct packed {
    logic [47:0] mac;
    logic [12:0] vid;
    logic [5:0]  dest;
    logic        bdom;
    logic [1:0]  etype;
    logic        aged;
    logic        cpu;
    logic        skill;
    logic        ign;
  } mtc_entry_s;
  // Engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SCAN} mtc_state_e;
endpackage : mtc_pkg

// File: verilog/mtc_engine.sv
// Software command engine for the hashed station table.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "mtc_params.svh"
// Overview of operation
// - Command code written starts each operation.
// - Learn inserts staged entry at hashed row.
// - Unlearn removes entry matching staged key.
// - Age scans, init clears, no staging needed.
// - Direct read returns entry, command goes idle.
// - Lookup reports hit in valid bit.
// - Write stores staged entry at index.
// - Get-next finds smallest key above staged.
// - Get-next searches one domain only.
// - Get-next reports found entry in registers.
// - Idle code shown when engine accepts.
// - Type 2 matches 01005E plus low 24.
// - Type 2 ports from address bits 34-24.
// - Type 3 matches 3333 plus low 32.
// - Type 3 ports from address bits 42-32.
// - Filter limits age scan and get-next.
// - Get-next ignores the domain filter.
// - All enabled filter conditions must hold.
// - 2048 rows, four buckets, 11-bit hash.
// - Age removes aged type 0, marks others.
// - Types: aging, locked, IPv4, IPv6.
module mtc_engine
  import mtc_pkg::*;
#(
  parameter int ROWS = 2048
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             busy_o
);
  // ****************************************
  // Sizes and storage
  // ****************************************
  localparam int RW = $clog2(ROWS);
  localparam int IW = RW + 2;
  localparam int N  = ROWS * 4;
  localparam logic [IW-1:0] LAST = IW'(N - 1);

  mtc_entry_s      mem_r [N];       // Entry bodies, rewritten by init.
  logic [N-1:0]    valid_r;         // Valid bits, cleared at reset.
  mtc_state_e      st_r;            // Engine state.
  logic [IW-1:0]   scan_r;          // Scan position.
  logic [47:0]     mac_r;           // Staged station address.
  logic [12:0]     vid_r;           // Staged VLAN.
  logic [RW-1:0]   row_r;           // Staged row.
  logic [1:0]      bkt_r;           // Staged bucket.
  logic [2:0]      cmd_r;           // Command field.
  logic            vld_r;           // Valid bit of the access register.
  logic [5:0]      dest_r;          // Port group pointer.
  logic            bdom_r;          // Backbone domain bit.
  logic [1:0]      type_r;          // Entry type.
  logic            aged_r;          // Aged flag.
  logic            cpu_r;           // Copy to processor.
  logic            skill_r;         // Source kill.
  logic            ign_r;           // Ignore VLAN mask.
  logic            fpe_r;           // Port filter enable.
  logic [5:0]      fport_r;         // Port filter value.
  logic            fve_r;           // VLAN filter enable.
  logic [12:0]     fvid_r;          // VLAN filter value.
  logic            fde_r;           // Domain filter enable.
  logic            fdom_r;          // Domain filter value.
  logic            bfound_r;        // Get-next has a candidate.
  logic [IW-1:0]   bidx_r;          // Index of the candidate.
  logic [`MTC_KEY_W-1:0] bkey_r;    // Key of the candidate.
  mtc_entry_s      stg;             // Staged entry.
  logic [RW-1:0]   hrow;            // Hashed row of the staged key.
  logic [3:0]      hit_v;           // Key matches per bucket.
  logic [3:0]      free_v;          // Empty buckets in the row.
  logic            hit;             // Key found.
  logic            free;            // Room in the row.
  logic [1:0]      hb;              // Bucket of the match.
  logic [1:0]      fb;              // First empty bucket.
  logic [IW-1:0]   didx;            // Direct index.
  logic            wr_en;           // Table write enable.
  logic [IW-1:0]   wr_idx;          // Table write index.
  mtc_entry_s      wr_d;            // Table write body.
  logic            wr_v;            // Table write valid.
  logic            acc_wr;          // Software writes the access register.
  logic            scan_end;        // Last scan step.
  logic            gn_take;         // Scan entry beats the candidate.
  mtc_entry_s      se;              // Entry under the scan.
  logic [47:0]     dmac;            // Frame address the staged entry matches.

  // ****************************************
  // Functions
  // ****************************************
  // Folds key into the row number by XOR of 11-bit slices.
  function automatic logic [10:0] hash(input logic [47:0] m, input logic [12:0] v);
    logic [65:0] k;
    k = {5'h0_0, v, m};
    hash = k[10:0] ^ k[21:11] ^ k[32:22] ^ k[43:33] ^ k[54:44] ^ k[65:55];
  endfunction : hash

  // Search key with the VLAN on top.
  function automatic logic [`MTC_KEY_W-1:0] key_of(input mtc_entry_s e);
    key_of = {e.vid[11:0], e.mac};
  endfunction : key_of

  // True when the entry passes every enabled filter term; the domain term counts only when use_dom is set.
  function automatic logic pass(input mtc_entry_s e, input logic use_dom);
    pass = (!fpe_r || e.dest == fport_r)
        && (!fve_r || e.vid == fvid_r)
        && (!use_dom || !fde_r || e.bdom == fdom_r);
  endfunction : pass

  // Destination port set carried by a multicast entry.
  function automatic logic [10:0] mc_ports(input mtc_entry_s e);
    case (e.etype)
      `MTC_TYPE_IPV4: mc_ports = e.mac[34:24];
      `MTC_TYPE_IPV6: mc_ports = e.mac[42:32];
      default:        mc_ports = 11'h000;
    endcase
  endfunction : mc_ports

  // Frame destination address that a multicast entry matches.
  function automatic logic [47:0] mc_dmac(input mtc_entry_s e);
    case (e.etype)
      `MTC_TYPE_IPV4: mc_dmac = {`MTC_V4_PREFIX, e.mac[23:0]};
      `MTC_TYPE_IPV6: mc_dmac = {`MTC_V6_PREFIX, e.mac[31:0]};
      default:        mc_dmac = e.mac;
    endcase
  endfunction : mc_dmac

  // ****************************************
  // Row compare
  // ****************************************
  assign stg  = {mac_r, vid_r, dest_r, bdom_r, type_r, aged_r, cpu_r, skill_r, ign_r};
  assign hrow = RW'(hash(mac_r, vid_r));
  assign didx = {row_r, bkt_r};
  assign se   = mem_r[scan_r];
  assign acc_wr = ce_i && reg_wr_i && reg_addr_i == `MTC_OFF_ACCESS;
  assign scan_end = scan_r == LAST;
  assign busy_o = st_r != ST_IDLE;
  assign dmac   = mc_dmac(stg);

  // All four buckets of the hashed row are compared at once.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bkt
      assign hit_v[g]  = valid_r[{hrow, 2'(g)}] && mem_r[{hrow, 2'(g)}].mac == mac_r
                       && mem_r[{hrow, 2'(g)}].vid == vid_r;
      assign free_v[g] = !valid_r[{hrow, 2'(g)}];
    end
  endgenerate

  // Lowest matching and lowest empty bucket.
  always_comb
  begin
    hb = 2'h0;
    fb = 2'h0;
    for (int b = 3; b >= 0; b--)
    begin
      if (hit_v[b]) hb = 2'(b);
      if (free_v[b]) fb = 2'(b);
    end
  end
  assign hit  = |hit_v;
  assign free = |free_v;

  // A scanned entry is a better get-next answer than the one held.
  // Kept in a process so that the filter registers read inside pass() wake it.
  always_comb
  begin
    gn_take = valid_r[scan_r] && se.bdom == bdom_r && pass(se, 1'b0)
           && key_of(se) > key_of(stg)
           && (!bfound_r || key_of(se) < bkey_r);
  end

  // ****************************************
  // Table write decision
  // ****************************************
  // One write port serves every command; a full row drops a learn.
  always_comb
  begin
    wr_en  = 1'b0;
    wr_idx = didx;
    wr_d   = stg;
    wr_v   = 1'b1;
    if (st_r == ST_EXEC)
    begin
      case (cmd_r)
        `MTC_CMD_LEARN:
        begin
          wr_en  = hit || free;
          wr_idx = {hrow, hit ? hb : fb};
        end
        `MTC_CMD_UNLRN:
        begin
          wr_en  = hit;
          wr_idx = {hrow, hb};
          wr_d   = mem_r[{hrow, hb}];
          wr_v   = 1'b0;
        end
        `MTC_CMD_WRITE:
        begin
          wr_en = 1'b1;
          wr_v  = vld_r;
        end
        default:
        begin
          wr_en = 1'b0;
        end
      endcase
    end
    else if (st_r == ST_SCAN)
    begin
      wr_idx = scan_r;
      wr_d   = se;
      case (cmd_r)
        `MTC_CMD_INIT:
        begin
          wr_en = 1'b1;
          wr_d  = '0;
          wr_v  = 1'b0;
        end
        `MTC_CMD_AGE:
        begin
          wr_en  = valid_r[scan_r] && pass(se, 1'b1);
          wr_d.aged = 1'b1;
          wr_v   = !(se.aged && se.etype == `MTC_TYPE_AGING);
        end
        default:
        begin
          wr_en = 1'b0;
        end
      endcase
    end
  end

  // Entry bodies; no reset, init clears them.
  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && wr_en) mem_r[wr_idx] <= wr_d;
  end

  // Valid bits.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i) valid_r <= '0;
    else if (ce_i && wr_en) valid_r[wr_idx] <= wr_v;
  end

  // ****************************************
  // Engine state
  // ****************************************
  // Single-entry commands take one busy cycle; scans one cycle per entry.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_r   <= ST_IDLE;
      scan_r <= '0;
    end
    else if (ce_i)
    begin
      case (st_r)
        ST_IDLE:
        begin
          scan_r <= '0;
          if (acc_wr)
          begin
            case (reg_wdata_i[2:0])
              `MTC_CMD_IDLE:                          st_r <= ST_IDLE;
              `MTC_CMD_AGE, `MTC_CMD_INIT, `MTC_CMD_GNEXT: st_r <= ST_SCAN;
              default:                                st_r <= ST_EXEC;
            endcase
          end
        end
        ST_EXEC: st_r <= ST_IDLE;
        ST_SCAN:
        begin
          scan_r <= scan_r + 1'b1;
          if (scan_end) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Best get-next candidate so far.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || (ce_i && st_r == ST_IDLE))
    begin
      bfound_r <= 1'b0;
      bidx_r   <= '0;
      bkey_r   <= '0;
    end
    else if (ce_i && st_r == ST_SCAN && cmd_r == `MTC_CMD_GNEXT && gn_take)
    begin
      bfound_r <= 1'b1;
      bidx_r   <= scan_r;
      bkey_r   <= key_of(se);
    end
  end

  // ****************************************
  // Staging registers
  // ****************************************
  // Software writes are taken only while idle so a running command
  // sees stable operands; results land as the command ends.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mac_r <= '0; vid_r <= '0; row_r <= '0; bkt_r <= '0;
      cmd_r <= `MTC_CMD_IDLE; vld_r <= 1'b0; dest_r <= '0; bdom_r <= 1'b0;
      type_r <= `MTC_TYPE_AGING; aged_r <= 1'b0; cpu_r <= 1'b0;
      skill_r <= 1'b0; ign_r <= 1'b0;
      fpe_r <= 1'b0; fport_r <= '0; fve_r <= 1'b0; fvid_r <= '0;
      fde_r <= 1'b0; fdom_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (st_r == ST_IDLE && reg_wr_i)
      begin
        case (reg_addr_i)
          `MTC_OFF_LDATA: mac_r[31:0] <= reg_wdata_i;
          `MTC_OFF_HDATA:
          begin
            mac_r[47:32] <= reg_wdata_i[15:0];
            vid_r        <= reg_wdata_i[28:16];
          end
          `MTC_OFF_INDEX:
          begin
            row_r <= reg_wdata_i[RW-1:0];
            bkt_r <= reg_wdata_i[13:12];
          end
          `MTC_OFF_ACCESS:
          begin
            {dest_r, bdom_r, type_r, aged_r, cpu_r, skill_r, ign_r, vld_r, cmd_r}
              <= reg_wdata_i[16:0];
          end
          `MTC_OFF_FILTER:
          begin
            {fdom_r, fde_r, fvid_r, fve_r, fport_r, fpe_r} <= reg_wdata_i[22:0];
          end
          default: ;
        endcase
      end
      else if (st_r == ST_EXEC)
      begin
        cmd_r <= `MTC_CMD_IDLE;
        if (cmd_r == `MTC_CMD_READ && vld_r)
        begin
          vld_r <= hit;
          if (hit)
            {dest_r, bdom_r, type_r, aged_r, cpu_r, skill_r, ign_r}
              <= mem_r[{hrow, hb}][12:0];
        end
        else if (cmd_r == `MTC_CMD_READ)
        begin
          vld_r <= valid_r[didx];
          {mac_r, vid_r, dest_r, bdom_r, type_r, aged_r, cpu_r, skill_r, ign_r}
            <= mem_r[didx];
        end
      end
      else if (st_r == ST_SCAN && scan_end)
      begin
        cmd_r <= `MTC_CMD_IDLE;
        if (cmd_r == `MTC_CMD_GNEXT)
        begin
          vld_r <= bfound_r || gn_take;
          if (gn_take)
            {mac_r, vid_r, dest_r, bdom_r, type_r, aged_r, cpu_r, skill_r, ign_r}
              <= se;
          else if (bfound_r)
            {mac_r, vid_r, dest_r, bdom_r, type_r, aged_r, cpu_r, skill_r, ign_r}
              <= mem_r[bidx_r];
        end
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Data stand in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i) reg_rdata_o <= '0;
    else if (ce_i && reg_rd_i)
    begin
      case (reg_addr_i)
        `MTC_OFF_LDATA:  reg_rdata_o <= mac_r[31:0];
        `MTC_OFF_HDATA:  reg_rdata_o <= {3'h0, vid_r, mac_r[47:32]};
        `MTC_OFF_INDEX:  reg_rdata_o <= {18'h0_0000, bkt_r, 12'(row_r)};
        `MTC_OFF_ACCESS: reg_rdata_o <= {15'h0000, dest_r, bdom_r, type_r, aged_r,
                                         cpu_r, skill_r, ign_r, vld_r, cmd_r};
        `MTC_OFF_FILTER: reg_rdata_o <= {9'h000, fdom_r, fde_r, fvid_r, fve_r,
                                         fport_r, fpe_r};
        `MTC_OFF_PORTS:  reg_rdata_o <= {21'h00_0000, mc_ports(stg)};
        `MTC_OFF_DMACL:  reg_rdata_o <= dmac[31:0];
        `MTC_OFF_DMACH:  reg_rdata_o <= {16'h0000, dmac[47:32]};
        default:         reg_rdata_o <= '0;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start_one;
    ce_i && st_r == ST_IDLE && acc_wr && reg_wdata_i[2:0] == `MTC_CMD_WRITE;
  endsequence
  sequence s_busy_then_idle;
    ##1 (cmd_r == `MTC_CMD_WRITE) ##1 (cmd_r == `MTC_CMD_IDLE && st_r == ST_IDLE);
  endsequence

  AST_ONE_CYCLE: assert property (s_start_one |-> s_busy_then_idle)
    else $error("Write command did not finish in one busy cycle.");
  AST_IDLE_CODE: assert property ((st_r == ST_IDLE) == (cmd_r == `MTC_CMD_IDLE))
    else $error("Command field disagrees with engine state.");
  AST_STAGE_HOLD: assert property (ce_i && st_r == ST_SCAN && !scan_end
    |=> $stable(mac_r) && $stable(vid_r))
    else $error("Staging changed during a scan.");
  AST_WRITE_AT: assert property (ce_i && st_r == ST_EXEC && cmd_r == `MTC_CMD_WRITE
    |=> mem_r[$past(didx)] == $past(stg))
    else $error("Write did not land at the index.");
  AST_UNLEARN: assert property (ce_i && st_r == ST_EXEC && cmd_r == `MTC_CMD_UNLRN && hit
    |=> !valid_r[$past(wr_idx)])
    else $error("Unlearn left the entry valid.");
  AST_AGE_DROP: assert property (ce_i && st_r == ST_SCAN && cmd_r == `MTC_CMD_AGE
    && valid_r[scan_r] && pass(se, 1'b1) && se.aged && se.etype == `MTC_TYPE_AGING
    |=> !valid_r[$past(scan_r)])
    else $error("Aged entry survived the scan.");
  AST_SCAN_STEP: assert property (ce_i && st_r == ST_SCAN && !scan_end
    |=> scan_r == $past(scan_r) + 1'b1)
    else $error("Scan skipped an entry.");
  AST_V4_PORTS: assert property (type_r == `MTC_TYPE_IPV4 && ce_i && reg_rd_i
    && reg_addr_i == `MTC_OFF_PORTS |=> reg_rdata_o[10:0] == $past(mac_r[34:24]))
    else $error("IPv4 port set wrong.");
  AST_GN_DOM: assert property (ce_i && st_r == ST_SCAN && cmd_r == `MTC_CMD_GNEXT
    |=> $stable(bdom_r) || st_r == ST_IDLE)
    else $error("Get-next domain changed mid search.");
endmodule : mtc_engine

// File: tb/tb_mtc_engine.sv
// Self-checking testbench for the station table command engine.
`timescale 1ns/1ps
`include "mtc_params.svh"
module tb_mtc_engine;
  // ****************************************
  // Signals and instance
  // ****************************************
  logic        sys_clk_i   = 1'b0;        // Core clock, 100 MHz.
  logic        rst_i       = 1'b1;        // Synchronous reset, held at start.
  logic [7:0]  reg_addr_i  = 8'h00;       // Register byte address.
  logic [31:0] reg_wdata_i = 32'h0000_0000; // Write data.
  logic        reg_wr_i    = 1'b0;        // Write strobe.
  logic        reg_rd_i    = 1'b0;        // Read strobe.
  logic [31:0] reg_rdata_o;               // Registered read data.
  logic        busy_o;                    // High while a command runs.
  logic [31:0] rdv;                       // Last value read.
  int          mismatches  = 0;           // Count of failed comparisons.
  int          comparisons = 0;           // Count of all comparisons.
  // Small table keeps scans at 64 cycles so polling stays cheap.
  mtc_engine #(.ROWS(16)) i_mtc_engine (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .ce_i        (1'b1),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .busy_o      (busy_o)
  );
  // Free-running clock, inverted every half period.
  always #5 sys_clk_i = ~sys_clk_i;
  // ****************************************
  // Tasks
  // ****************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // Compares one 32-bit result with its expected value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write; waiting an edge first avoids re-driving the strobe in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  // One-cycle read; data is taken in the cycle after the strobe only.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    rdv = reg_rdata_o;
  endtask : rd
  // Reads a register and compares the masked bits.
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdv & m, e);
  endtask : rc
  // Issues a command and polls the command field until idle, with a bound.
  task automatic cmd(input logic [31:0] w);
    int i;
    wr(`MTC_OFF_ACCESS, w);
    #1;
    chk({31'h0, busy_o}, 32'h0000_0001);
    for (i = 0; i < 200; i++)
    begin
      rd(`MTC_OFF_ACCESS);
      if (rdv[2:0] === `MTC_CMD_IDLE)
        break;
    end
    if (i == 200)
    begin
      mismatches++;
      $display("unexpected at %0t: command never went idle", $time);
      stop_test();
    end
    chk({31'h0, busy_o}, 32'h0000_0000);
  endtask : cmd
  // Stages the key of station A.
  task automatic stage_a();
    wr(`MTC_OFF_LDATA, 32'hAABB_CCDD);
    wr(`MTC_OFF_HDATA, 32'h0001_0000);
  endtask : stage_a
  // ****************************************
  // Get-next cases: filter, access word, hit expected
  // ****************************************
  logic [31:0] gn_flt [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0580,
                              32'h0060_0000, 32'h0000_0C87, 32'h0000_0C81};
  logic [31:0] gn_acc [6] = '{32'h0000_0007, 32'h0000_0407, 32'h0000_0007,
                              32'h0000_0007, 32'h0000_0007, 32'h0000_0007};
  logic        gn_hit [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rc(`MTC_OFF_ACCESS, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    cmd(32'h0000_0006);
    // Learn a locked station, then find it again by key.
    stage_a();
    cmd(32'h0000_2901);
    cmd(32'h0000_000C);
    rc(`MTC_OFF_ACCESS, 32'hFFFF_FFFF, 32'h0000_2908);
    // Stage an IPv4 group entry and check its derived ports and address.
    wr(`MTC_OFF_LDATA, 32'h0811_2233);
    wr(`MTC_OFF_HDATA, 32'h000C_0003);
    wr(`MTC_OFF_INDEX, 32'h0000_2003);
    wr(`MTC_OFF_ACCESS, 32'h0000_0208);
    rc(`MTC_OFF_PORTS, 32'hFFFF_FFFF, 32'h0000_0308);
    rc(`MTC_OFF_DMACL, 32'hFFFF_FFFF, 32'h5E11_2233);
    rc(`MTC_OFF_DMACH, 32'hFFFF_FFFF, 32'h0000_0100);
    cmd(32'h0000_020D);
    // An IPv6 group entry is only staged, never stored.
    wr(`MTC_OFF_LDATA, 32'h0011_2233);
    wr(`MTC_OFF_HDATA, 32'h000C_0308);
    wr(`MTC_OFF_ACCESS, 32'h0000_0308);
    rc(`MTC_OFF_PORTS, 32'hFFFF_FFFF, 32'h0000_0308);
    rc(`MTC_OFF_DMACL, 32'hFFFF_FFFF, 32'h0011_2233);
    rc(`MTC_OFF_DMACH, 32'hFFFF_FFFF, 32'h0000_3333);
    // Direct read of the stored group entry.
    wr(`MTC_OFF_LDATA, 32'h0000_0000);
    wr(`MTC_OFF_HDATA, 32'h0000_0000);
    cmd(32'h0000_0004);
    rc(`MTC_OFF_LDATA, 32'hFFFF_FFFF, 32'h0811_2233);
    rc(`MTC_OFF_HDATA, 32'hFFFF_FFFF, 32'h000C_0003);
    rc(`MTC_OFF_ACCESS, 32'hFFFF_FFFF, 32'h0000_0208);
    // Unlearn station A and confirm the lookup misses.
    stage_a();
    cmd(32'h0000_0002);
    cmd(32'h0000_000C);
    rc(`MTC_OFF_ACCESS, 32'h0000_0008, 32'h0000_0000);
    // Get-next from key zero under each domain and filter setting.
    for (int k = 0; k < 6; k++)
    begin
      wr(`MTC_OFF_FILTER, gn_flt[k]);
      wr(`MTC_OFF_LDATA, 32'h0000_0000);
      wr(`MTC_OFF_HDATA, 32'h0000_0000);
      cmd(gn_acc[k]);
      rc(`MTC_OFF_ACCESS, 32'h0000_0008, {28'h0, gn_hit[k], 3'h0});
      if (gn_hit[k])
      begin
        rc(`MTC_OFF_ACCESS, 32'hFFFF_FFFF, 32'h0000_0208);
        rc(`MTC_OFF_LDATA, 32'hFFFF_FFFF, 32'h0811_2233);
        rc(`MTC_OFF_HDATA, 32'hFFFF_FFFF, 32'h000C_0003);
      end
    end
    wr(`MTC_OFF_FILTER, 32'h0000_0000);
    // Relearn A as an aging entry; staging must survive a running scan.
    stage_a();
    cmd(32'h0000_2801);
    wr(`MTC_OFF_LDATA, 32'h1234_5678);
    wr(`MTC_OFF_ACCESS, 32'h0000_0003);
    wr(`MTC_OFF_LDATA, 32'hFFFF_FFFF);
    rc(`MTC_OFF_ACCESS, 32'h0000_0007, 32'h0000_0003);
    cmd(32'h0000_0000);
    rc(`MTC_OFF_LDATA, 32'hFFFF_FFFF, 32'h1234_5678);
    stage_a();
    cmd(32'h0000_000C);
    rc(`MTC_OFF_ACCESS, 32'hFFFF_FFFF, 32'h0000_2888);
    // A plain aging entry carries no port set and matches its own address.
    rc(`MTC_OFF_PORTS, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(`MTC_OFF_DMACL, 32'hFFFF_FFFF, 32'hAABB_CCDD);
    cmd(32'h0000_0003);
    stage_a();
    cmd(32'h0000_000C);
    rc(`MTC_OFF_ACCESS, 32'h0000_0008, 32'h0000_0000);
    // The group entry survives both scans with its aged flag set.
    wr(`MTC_OFF_INDEX, 32'h0000_2003);
    cmd(32'h0000_0004);
    rc(`MTC_OFF_ACCESS, 32'hFFFF_FFFF, 32'h0000_0288);
    stop_test();
  end
endmodule : tb_mtc_engine
